// ---- pkg/sos_cfg.svh ----
// constants of the status output selector: codes, levels, scales and timing
`ifndef SOS_CFG_SVH
`define SOS_CFG_SVH

// control clock rate and derived time bases
`define SOS_CLK_HZ          10000000
`define SOS_TICK_MS         1
`define SOS_RETRY_HOLD_MS   100
`define SOS_HALF_THRESH     30'h1dcd6500

// digital output function codes
`define SOS_FC_PULSE        5'h0e
`define SOS_FC_UNDERVOLT    5'h0f
`define SOS_FC_OVERHEAT     5'h10
`define SOS_FC_MOTOR_OL     5'h11
`define SOS_FC_DRIVE_OL     5'h12
`define SOS_FC_RETRY        5'h13
`define SOS_FC_TIMER        5'h15
`define SOS_FC_COMM         5'h16
`define SOS_FC_EXCESS_NC    5'h17
`define SOS_FC_LAST         5'h1c

// input terminal code that marks a timer input
`define SOS_IN_TIMER        5'h13

// dc bus undervoltage alarm levels and monitor full scale, volts
`define SOS_UV_230          10'h0f0
`define SOS_UV_460          10'h1cc
`define SOS_DCFS_230        10'h190
`define SOS_DCFS_460        10'h320

// pulse multipliers per gain setting 0..4
`define SOS_MULT_0          6'h01
`define SOS_MULT_1          6'h06
`define SOS_MULT_2          6'h0a
`define SOS_MULT_3          6'h0c
`define SOS_MULT_4          6'h24
`define SOS_GAIN_SEL_LAST   3'h4

// valid output frequency window per gain setting, 0.01 Hz units
`define SOS_LO_0            16'h017f
`define SOS_HI_0            16'h9c40
`define SOS_LO_1            16'h0100
`define SOS_HI_1            16'h8ca0
`define SOS_LO_2            16'h009a
`define SOS_HI_2            16'h5208
`define SOS_LO_3            16'h0080
`define SOS_HI_3            16'h4650
`define SOS_LO_4            16'h0032
`define SOS_HI_4            16'h1770

// analog monitor codes and converter scale
`define SOS_MON_DCV         4'h4
`define SOS_MON_COMM        4'hb
`define SOS_MON_LAST        4'he
`define SOS_DAC_MAX         12'hfff
`define SOS_GAIN_UNITY      20'h00064

`endif

// ---- pkg/sos_pkg.sv ----
// types shared by the status output selector modules
package sos_pkg;
  typedef logic [4:0]  sos_func_code_t;
  typedef logic [3:0]  sos_mon_code_t;
  typedef logic [11:0] sos_dac_t;
  typedef logic [7:0]  sos_gain_t;
  typedef logic [15:0] sos_freq_t;
  typedef enum logic [1:0] {
    SOS_T_LOW,
    SOS_T_RISE_WAIT,
    SOS_T_HIGH,
    SOS_T_FALL_WAIT
  } sos_timer_state_t;
endpackage

// ---- pkg/sos_pulse_if.sv ----
// signals between the selector core and the pulse train generator
`timescale 1ns/100ps
interface sos_pulse_if;
  import sos_pkg::*;
  logic      enable;
  logic [2:0] gain_sel;
  sos_freq_t freq;
  logic      pulse;
  logic      range_err;
  modport gen (input enable, input gain_sel, input freq, output pulse, output range_err);
  modport ctl (output enable, output gain_sel, output freq, input pulse, input range_err);
endinterface

// ---- design/sos_pulse_gen.sv ----
// pulse train generator: output frequency times a selectable multiplier, half duty
`timescale 1ns/100ps
`include "sos_cfg.svh"
module sos_pulse_gen (
  input  wire logic clock,
  input  wire logic rst,
  sos_pulse_if.gen  pif
);
  import sos_pkg::*;

  logic [29:0] acc_r;
  logic [29:0] acc_nxt;
  logic        pulse_r;
  logic        pulse_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [5:0]  mult;
  sos_freq_t   lo;
  sos_freq_t   hi;
  logic [29:0] step;
  logic [29:0] sum;

  // multiplier and valid window for the chosen gain setting
  always_comb begin
    case (pif.gain_sel)
      3'h0: begin mult = `SOS_MULT_0; lo = `SOS_LO_0; hi = `SOS_HI_0; end
      3'h1: begin mult = `SOS_MULT_1; lo = `SOS_LO_1; hi = `SOS_HI_1; end
      3'h2: begin mult = `SOS_MULT_2; lo = `SOS_LO_2; hi = `SOS_HI_2; end
      3'h3: begin mult = `SOS_MULT_3; lo = `SOS_LO_3; hi = `SOS_HI_3; end
      3'h4: begin mult = `SOS_MULT_4; lo = `SOS_LO_4; hi = `SOS_HI_4; end
      default: begin mult = 6'h00; lo = 16'hffff; hi = 16'h0000; end
    endcase
  end

  // phase accumulator toggles each half period, so high and low last equally long
  always_comb begin
    step      = 30'(pif.freq * mult);
    sum       = acc_r + step;
    err_nxt   = pif.enable && ((pif.freq < lo) || (pif.freq > hi));
    acc_nxt   = acc_r;
    pulse_nxt = pulse_r;
    if (!pif.enable || err_nxt) begin
      acc_nxt   = 30'h0;
      pulse_nxt = 1'b0; // out of window: held low rather than a wrong rate
    end else if (sum >= `SOS_HALF_THRESH) begin
      acc_nxt   = sum - `SOS_HALF_THRESH; // remainder kept, no drift
      pulse_nxt = ~pulse_r;
    end else begin
      acc_nxt   = sum;
    end
  end

  // generator state
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r   <= 30'h0;
      pulse_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      pulse_r <= pulse_nxt;
      err_r   <= err_nxt;
    end
  end

  assign pif.pulse     = pulse_r;
  assign pif.range_err = err_r;
endmodule

// ---- design/sos_on_off_delay.sv ----
// timer output: follows its input with separate rise and fall delays in ms
`timescale 1ns/100ps
`include "sos_cfg.svh"
module sos_on_off_delay (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        tick_ms,
  input  wire logic        din,
  input  wire logic [15:0] on_delay_ms,
  input  wire logic [15:0] off_delay_ms,
  output logic             dout
);
  import sos_pkg::*;

  sos_timer_state_t st_r;
  sos_timer_state_t st_nxt;
  logic [15:0]      cnt_r;
  logic [15:0]      cnt_nxt;

  // a change of input during a wait cancels the wait, so short glitches never pass
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      SOS_T_LOW: begin
        cnt_nxt = 16'h0;
        if (din) st_nxt = SOS_T_RISE_WAIT;
      end
      SOS_T_RISE_WAIT: begin
        if (!din) begin
          st_nxt = SOS_T_LOW;
        end else if (cnt_r >= on_delay_ms) begin
          st_nxt  = SOS_T_HIGH;
          cnt_nxt = 16'h0;
        end else if (tick_ms) begin
          cnt_nxt = cnt_r + 16'h1;
        end
      end
      SOS_T_HIGH: begin
        cnt_nxt = 16'h0;
        if (!din) st_nxt = SOS_T_FALL_WAIT;
      end
      SOS_T_FALL_WAIT: begin
        if (din) begin
          st_nxt = SOS_T_HIGH;
        end else if (cnt_r >= off_delay_ms) begin
          st_nxt  = SOS_T_LOW;
          cnt_nxt = 16'h0;
        end else if (tick_ms) begin
          cnt_nxt = cnt_r + 16'h1;
        end
      end
      default: begin
        st_nxt  = SOS_T_LOW;
        cnt_nxt = 16'h0;
      end
    endcase
  end

  // timer state
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r  <= SOS_T_LOW;
      cnt_r <= 16'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dout = (st_r == SOS_T_HIGH) || (st_r == SOS_T_FALL_WAIT);
endmodule

// ---- design/sos_top.sv ----
// status output selector: digital output terminals, pulse train and analog monitors
`timescale 1ns/100ps
`include "sos_cfg.svh"
module sos_top
  import sos_pkg::*;
#(
  parameter int RETRY_HOLD_CYC = `SOS_RETRY_HOLD_MS * (`SOS_CLK_HZ / 1000),
  parameter int TICK_CYC       = `SOS_TICK_MS * (`SOS_CLK_HZ / 1000)
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire sos_pkg::sos_func_code_t output_selector_a,
  input  wire sos_pkg::sos_func_code_t output_selector_b,
  input  wire sos_pkg::sos_func_code_t output_selector_c,
  input  wire logic [2:0]              pulse_gain_setting,
  input  wire sos_pkg::sos_freq_t      output_freq_centi_hz,
  input  wire logic [9:0]              dc_bus_volts,
  input  wire logic                    volt_class_460,
  input  wire logic                    heatsink_overheat,
  input  wire logic                    motor_overload,
  input  wire logic                    drive_overload,
  input  wire logic                    fault_restart_pulse,
  input  wire logic [2:0]              comm_output_cmd,
  input  wire logic [31:0]             status_flags,
  input  wire sos_pkg::sos_func_code_t input_function_selector [4],
  input  wire logic [3:0]              input_terminal,
  input  wire logic [15:0]             timer_on_delay_ms,
  input  wire logic [15:0]             timer_off_delay_ms,
  input  wire sos_pkg::sos_mon_code_t  analog_monitor_select_one,
  input  wire sos_pkg::sos_mon_code_t  analog_monitor_select_two,
  input  wire sos_pkg::sos_gain_t      monitor_gain_one,
  input  wire sos_pkg::sos_gain_t      monitor_gain_two,
  input  wire sos_pkg::sos_dac_t       monitor_quantity [15],
  input  wire sos_pkg::sos_dac_t       comm_monitor_one,
  input  wire sos_pkg::sos_dac_t       comm_monitor_two,
  output logic                         terminal_out_a,
  output logic                         photocoupler_output,
  output logic                         terminal_out_c,
  output logic                         pulse_range_error,
  output sos_pkg::sos_dac_t            analog_monitor_out_one,
  output sos_pkg::sos_dac_t            analog_monitor_out_two
);
  import sos_pkg::*;

  // ---------------------------------------------------------------- pin sync
  // only stage two reads stage one
  logic [3:0] term_meta_r;
  logic [3:0] term_sync_r;

  // terminals are outside the clock domain; nothing but stage two reads the first stage
  always_ff @(posedge clock) begin
    if (rst) begin
      term_meta_r <= 4'h0;
      term_sync_r <= 4'h0;
    end else begin
      term_meta_r <= input_terminal;
      term_sync_r <= term_meta_r;
    end
  end

  // ------------------------------------------------------------- millisecond tick
  // wide enough for slow clocks
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic        tick_ms_r;
  logic        tick_ms_nxt;

  // free running divider gives a one-cycle enable each millisecond
  always_comb begin
    tick_ms_nxt  = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h1;
    if (tick_cnt_r >= 32'(TICK_CYC - 1)) begin
      tick_cnt_nxt = 32'h0;
      tick_ms_nxt  = 1'b1;
    end
  end

  // divider state, reset restarts it
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt_r <= 32'h0;
      tick_ms_r  <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_ms_r  <= tick_ms_nxt;
    end
  end

  // ------------------------------------------------------------- timer input
  logic timer_in;
  logic timer_out;

  // the lowest numbered terminal coded as timer input feeds the delay
  always_comb begin
    timer_in = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (input_function_selector[i] == `SOS_IN_TIMER) timer_in = term_sync_r[i];
    end
  end

  // on and off delay of timer input
  sos_on_off_delay u_timer (
    .clock        (clock),
    .rst          (rst),
    .tick_ms      (tick_ms_r),
    .din          (timer_in),
    .on_delay_ms  (timer_on_delay_ms),
    .off_delay_ms (timer_off_delay_ms),
    .dout         (timer_out)
  );

  // ------------------------------------------------------------- fault retry hold
  // retry stretch left, in cycles
  logic [31:0] retry_cnt_r;
  logic [31:0] retry_cnt_nxt;

  // a restart is a single pulse; stretch it so a relay load can see it
  always_comb begin
    retry_cnt_nxt = retry_cnt_r;
    if (fault_restart_pulse) begin
      retry_cnt_nxt = 32'(RETRY_HOLD_CYC);
    end else if (retry_cnt_r != 32'h0) begin
      retry_cnt_nxt = retry_cnt_r - 32'h1;
    end
  end

  // hold counter state
  always_ff @(posedge clock) begin
    if (rst) begin
      retry_cnt_r <= 32'h0;
    end else begin
      retry_cnt_r <= retry_cnt_nxt;
    end
  end

  // ------------------------------------------------------------- pulse train
  // pulse train carrier
  sos_pulse_if pif ();

  // enabled only by terminal b
  assign pif.enable   = (output_selector_b == `SOS_FC_PULSE);
  assign pif.gain_sel = pulse_gain_setting;
  assign pif.freq     = output_freq_centi_hz;

  // idles low when not enabled
  sos_pulse_gen u_pulse (
    .clock (clock),
    .rst   (rst),
    .pif   (pif)
  );

  // window error brought out
  assign pulse_range_error = pif.range_err;

  // ------------------------------------------------------------- conditions
  logic [31:0] cond;
  logic        undervolt;

  // undervoltage level depends on the voltage class strap
  assign undervolt = volt_class_460 ? (dc_bus_volts < `SOS_UV_460)
                                    : (dc_bus_volts < `SOS_UV_230);

  // one condition per function code; codes not derived here come from the drive
  always_comb begin
    cond                    = status_flags;
    cond[`SOS_FC_PULSE]     = 1'b0;
    cond[`SOS_FC_UNDERVOLT] = undervolt;
    cond[`SOS_FC_OVERHEAT]  = heatsink_overheat;
    cond[`SOS_FC_MOTOR_OL]  = motor_overload;
    cond[`SOS_FC_DRIVE_OL]  = drive_overload;
    cond[`SOS_FC_RETRY]     = (retry_cnt_r != 32'h0);
    cond[`SOS_FC_TIMER]     = timer_out;
    cond[31:29]             = 3'h0;
  end

  // ------------------------------------------------------------- digital outputs
  // per terminal code and level
  sos_func_code_t sel [3];
  logic [2:0]     dout_r;
  logic [2:0]     dout_nxt;

  // selectors gathered for one loop
  assign sel[0] = output_selector_a;
  assign sel[1] = output_selector_b;
  assign sel[2] = output_selector_c;

  // each terminal picks its condition; only terminal b may carry the pulse train
  for (genvar t = 0; t < 3; t++) begin : g_dout
    always_comb begin
      if (sel[t] == `SOS_FC_COMM) begin
        dout_nxt[t] = comm_output_cmd[t];
      end else if (sel[t] == `SOS_FC_EXCESS_NC) begin
        dout_nxt[t] = ~status_flags[`SOS_FC_EXCESS_NC];
      end else if (sel[t] == `SOS_FC_PULSE) begin
        dout_nxt[t] = (t == 1) ? pif.pulse : 1'b0;
      end else if (sel[t] > `SOS_FC_LAST) begin
        dout_nxt[t] = 1'b0;
      end else begin
        dout_nxt[t] = cond[sel[t]];
      end
    end
  end

  // terminals change only on an edge
  always_ff @(posedge clock) begin
    if (rst) begin
      dout_r <= 3'h0;
    end else begin
      dout_r <= dout_nxt;
    end
  end

  // registered terminal levels
  assign terminal_out_a      = dout_r[0];
  assign photocoupler_output = dout_r[1];
  assign terminal_out_c      = dout_r[2];

  // ------------------------------------------------------------- dc voltage scale
  // divide is combinational, a cycle to settle
  logic [9:0]  dc_fs;
  logic [21:0] dc_prod;
  logic [21:0] dc_ratio;
  sos_dac_t    dcv_code;

  // full scale follows the class; above full scale the code saturates
  always_comb begin
    dc_fs    = volt_class_460 ? `SOS_DCFS_460 : `SOS_DCFS_230;
    dc_prod  = 22'(dc_bus_volts * `SOS_DAC_MAX);
    dc_ratio = dc_prod / 22'(dc_fs);
    dcv_code = (dc_ratio > 22'(`SOS_DAC_MAX)) ? `SOS_DAC_MAX : dc_ratio[11:0];
  end

  // ------------------------------------------------------------- analog monitors
  // monitor working values
  sos_mon_code_t msel  [2];
  sos_gain_t     mgain [2];
  sos_dac_t      mcomm [2];
  sos_dac_t      mval  [2];
  logic [19:0]   mprod [2];
  logic [19:0]   mscl  [2];
  sos_dac_t      aout_r   [2];
  sos_dac_t      aout_nxt [2];

  // per monitor copies for the loop
  assign msel[0]  = analog_monitor_select_one;
  assign msel[1]  = analog_monitor_select_two;
  assign mgain[0] = monitor_gain_one;
  assign mgain[1] = monitor_gain_two;
  assign mcomm[0] = comm_monitor_one;
  assign mcomm[1] = comm_monitor_two;

  // select a quantity, apply gain in hundredths, saturate at converter maximum
  for (genvar m = 0; m < 2; m++) begin : g_mon
    always_comb begin
      if (msel[m] == `SOS_MON_DCV) begin
        mval[m] = dcv_code;
      end else if (msel[m] == `SOS_MON_COMM) begin
        mval[m] = mcomm[m];
      end else if (msel[m] <= `SOS_MON_LAST) begin
        mval[m] = monitor_quantity[msel[m]];
      end else begin
        mval[m] = 12'h000;
      end
      mprod[m] = 20'(mval[m] * mgain[m]);
      mscl[m]  = mprod[m] / `SOS_GAIN_UNITY;
      aout_nxt[m] = (mscl[m] > 20'(`SOS_DAC_MAX)) ? `SOS_DAC_MAX : mscl[m][11:0];
    end

    // registered, so the converter sees no glitch
    always_ff @(posedge clock) begin
      if (rst) begin
        aout_r[m] <= 12'h000;
      end else begin
        aout_r[m] <= aout_nxt[m];
      end
    end
  end

  // registered converter codes
  assign analog_monitor_out_one = aout_r[0];
  assign analog_monitor_out_two = aout_r[1];
endmodule

// ---- sim/sos_load_model.sv ----
// load on the photo-coupler terminal: times each high and low phase
`timescale 1ns/100ps
module sos_load_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        load_in,
  output logic      [31:0] high_len,
  output logic      [31:0] low_len,
  output logic      [31:0] edges
);
  logic        last_r;
  logic [31:0] run_r;
  // a counter input sees only level changes, so phases are timed in clock cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      last_r <= 1'b0;
      run_r <= 32'h0;
      high_len <= 32'h0;
      low_len <= 32'h0;
      edges <= 32'h0;
    end else if (load_in != last_r) begin
      last_r <= load_in;
      run_r <= 32'h1;
      edges <= edges + 32'h1;
      if (last_r)
        high_len <= run_r;
      else
        low_len <= run_r;
    end else begin
      run_r <= run_r + 32'h1;
    end
  end
endmodule

// ---- sim/sos_top_checker.sv ----
// assertions on the status output selector top ports
`timescale 1ns/100ps
`include "sos_cfg.svh"
module sos_top_checker (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire sos_pkg::sos_func_code_t output_selector_a,
  input wire sos_pkg::sos_func_code_t output_selector_b,
  input wire sos_pkg::sos_func_code_t output_selector_c,
  input wire logic [2:0]              pulse_gain_setting,
  input wire sos_pkg::sos_freq_t      output_freq_centi_hz,
  input wire logic [9:0]              dc_bus_volts,
  input wire logic                    volt_class_460,
  input wire logic                    heatsink_overheat,
  input wire logic                    drive_overload,
  input wire logic                    fault_restart_pulse,
  input wire logic [2:0]              comm_output_cmd,
  input wire logic [31:0]             status_flags,
  input wire sos_pkg::sos_mon_code_t  analog_monitor_select_one,
  input wire sos_pkg::sos_gain_t      monitor_gain_one,
  input wire logic                    terminal_out_a,
  input wire logic                    terminal_out_c,
  input wire logic                    pulse_range_error,
  input wire sos_pkg::sos_dac_t       analog_monitor_out_one
);
  import sos_pkg::*;
  logic        rst_q;
  logic        uv_now;
  logic [23:0] dc_raw;
  logic [11:0] dc_exp;
  // outputs stay low one edge past release, so checking waits one more cycle
  always_ff @(posedge clock) rst_q <= rst;
  // expected undervolt flag and dc monitor code from the present inputs
  assign uv_now = volt_class_460 ? (dc_bus_volts < `SOS_UV_460) : (dc_bus_volts < `SOS_UV_230);
  assign dc_raw = (24'(dc_bus_volts) * 24'hfff) / (volt_class_460 ? 24'h320 : 24'h190);
  assign dc_exp = (dc_raw > 24'hfff) ? 12'hfff : dc_raw[11:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst || rst_q);
  property p_pulse_only_b;
    output_selector_a == `SOS_FC_PULSE |=> !terminal_out_a;
  endproperty
  a_pulse_only_b: assert property (p_pulse_only_b) else $error("code 14 drove terminal a");
  property p_range;
    output_selector_b == `SOS_FC_PULSE && pulse_gain_setting == 3'h4
      && output_freq_centi_hz > `SOS_HI_4 |=> pulse_range_error;
  endproperty
  a_range: assert property (p_range) else $error("pulse range error missing");
  property p_undervolt;
    output_selector_a == `SOS_FC_UNDERVOLT |=> terminal_out_a == $past(uv_now);
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervolt output wrong");
  property p_overheat;
    output_selector_a == `SOS_FC_OVERHEAT |=> terminal_out_a == $past(heatsink_overheat);
  endproperty
  a_overheat: assert property (p_overheat) else $error("overheat output wrong");
  property p_drive_ol;
    output_selector_a == `SOS_FC_DRIVE_OL |=> terminal_out_a == $past(drive_overload);
  endproperty
  a_drive_ol: assert property (p_drive_ol) else $error("drive overload output wrong");
  property p_retry;
    fault_restart_pulse && output_selector_a == `SOS_FC_RETRY
      ##1 output_selector_a == `SOS_FC_RETRY [*2] |-> ##[0:1] terminal_out_a;
  endproperty
  a_retry: assert property (p_retry) else $error("retry output did not rise");
  property p_comm;
    output_selector_c == `SOS_FC_COMM |=> terminal_out_c == $past(comm_output_cmd[2]);
  endproperty
  a_comm: assert property (p_comm) else $error("commanded output wrong");
  property p_excess_nc;
    output_selector_a == `SOS_FC_EXCESS_NC |=> terminal_out_a != $past(status_flags[23]);
  endproperty
  a_excess_nc: assert property (p_excess_nc) else $error("excess load nc not inverted");
  property p_dc_mon;
    analog_monitor_select_one == `SOS_MON_DCV && monitor_gain_one == 8'h64
      |=> analog_monitor_out_one == $past(dc_exp);
  endproperty
  a_dc_mon: assert property (p_dc_mon) else $error("dc monitor code wrong");
endmodule
bind sos_top sos_top_checker u_chk (.*);

// ---- sim/testbench.sv ----
// self-checking bench for the status output selector
`timescale 1ns/100ps
`include "sos_cfg.svh"
module testbench;
  import sos_pkg::*;
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  sos_func_code_t output_selector_a = 5'h00;
  sos_func_code_t output_selector_b = 5'h00;
  sos_func_code_t output_selector_c = 5'h00;
  logic [2:0]     pulse_gain_setting = 3'h0;
  sos_freq_t      output_freq_centi_hz = 16'h0000;
  logic [9:0]     dc_bus_volts = 10'h000;
  logic           volt_class_460 = 1'b0;
  logic           heatsink_overheat = 1'b0;
  logic           motor_overload = 1'b0;
  logic           drive_overload = 1'b0;
  logic           fault_restart_pulse = 1'b0;
  logic [2:0]     comm_output_cmd = 3'h0;
  logic [31:0]    status_flags = 32'hffffffff;
  sos_func_code_t input_function_selector [4];
  logic [3:0]     input_terminal = 4'h0;
  logic [15:0]    timer_on_delay_ms = 16'h0003;
  logic [15:0]    timer_off_delay_ms = 16'h0002;
  sos_mon_code_t  analog_monitor_select_one = 4'h0;
  sos_mon_code_t  analog_monitor_select_two = 4'h0;
  sos_gain_t      monitor_gain_one = 8'h64;
  sos_gain_t      monitor_gain_two = 8'h64;
  sos_dac_t       monitor_quantity [15];
  sos_dac_t       comm_monitor_one = 12'hc00;
  sos_dac_t       comm_monitor_two = 12'hc00;
  logic           terminal_out_a;
  logic           photocoupler_output;
  logic           terminal_out_c;
  logic           pulse_range_error;
  sos_dac_t       analog_monitor_out_one;
  sos_dac_t       analog_monitor_out_two;
  logic [31:0]    high_len;
  logic [31:0]    low_len;
  logic [31:0]    edges;
  int             errors = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  int             mults [5] = '{1, 6, 10, 12, 36};
  sos_freq_t      his [5] = '{16'h9c40, 16'h8ca0, 16'h5208, 16'h4650, 16'h1770};

  // short counts keep the retry hold and ms tick inside a quick run
  sos_top #(.RETRY_HOLD_CYC(20), .TICK_CYC(4)) u_dut (.*);
  sos_load_model u_load (.clock(clock), .rst(rst), .load_in(photocoupler_output),
    .high_len(high_len), .low_len(low_len), .edges(edges));

  always #50 clock = ~clock;
  // hang guard: the whole run needs about 66000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // outputs are read at the falling edge, well clear of the launching edge
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  function automatic logic [31:0] near(input logic [31:0] m, input logic [31:0] h);
    return (m + 1 >= h && m <= h + 1) ? h : m;
  endfunction
  task automatic dig(input sos_func_code_t code, input logic ea, input logic ec);
    @(posedge clock);
    output_selector_a <= code;
    output_selector_c <= code;
    settle(2);
    check("terminal_a", terminal_out_a, ea);
    check("terminal_c", terminal_out_c, ec);
  endtask
  task automatic mon(input sos_mon_code_t s, input sos_gain_t g, input sos_dac_t exp);
    @(posedge clock);
    analog_monitor_select_one <= s;
    analog_monitor_select_two <= s;
    monitor_gain_one <= g;
    monitor_gain_two <= g;
    settle(2);
    check("monitor_one", analog_monitor_out_one, exp);
    check("monitor_two", analog_monitor_out_two, exp);
  endtask
  task automatic rng(input logic [2:0] g, input sos_freq_t f, input logic exp);
    @(posedge clock);
    pulse_gain_setting <= g;
    output_freq_centi_hz <= f;
    settle(2);
    check("range_error", pulse_range_error, exp);
  endtask
  // edge intervals quantise to whole cycles, so a one-cycle spread is allowed
  task automatic pulse_chk(input logic [2:0] g, input sos_freq_t f, input int mult);
    logic [31:0] e0;
    logic [31:0] half;
    half = 500000000 / (f * mult);
    @(posedge clock);
    pulse_gain_setting <= g;
    output_freq_centi_hz <= f;
    settle(1);
    e0 = edges;
    while (edges - e0 < 3)
      settle(1);
    check("pulse_high", near(high_len, half), half);
    check("pulse_low", near(low_len, high_len), high_len);
  endtask

  initial begin
    for (int k = 0; k < 15; k++)
      monitor_quantity[k] = 12'(16 * k + 1);
    for (int k = 0; k < 4; k++)
      input_function_selector[k] = (k == 2) ? `SOS_IN_TIMER : 5'h00;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    dig(`SOS_FC_PULSE, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      volt_class_460 <= k[1];
      dc_bus_volts <= k[1] ? 10'h1cb + 10'(k[0]) : 10'h0ef + 10'(k[0]);
      dig(`SOS_FC_UNDERVOLT, !k[0], !k[0]);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      {drive_overload, motor_overload, heatsink_overheat} <= 3'h1 << k;
      dig(5'(16 + k), 1'b1, 1'b1);
      dig(5'(16 + (k + 1) % 3), 1'b0, 1'b0);
    end
    for (int k = 23; k < 29; k++) begin
      @(posedge clock);
      status_flags <= 32'h1 << k;
      dig(5'(k), k != 23, k != 23);
      @(posedge clock);
      status_flags <= 32'h0;
      dig(5'(k), k == 23, k == 23);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      comm_output_cmd <= 3'(k);
      output_selector_b <= `SOS_FC_COMM;
      dig(`SOS_FC_COMM, k[0], k[2]);
      check("terminal_b", photocoupler_output, k[1]);
    end
    dig(`SOS_FC_RETRY, 1'b0, 1'b0);
    @(posedge clock);
    fault_restart_pulse <= 1'b1;
    @(posedge clock);
    fault_restart_pulse <= 1'b0;
    settle(3);
    check("retry_rise", terminal_out_a, 1'b1);
    settle(12);
    check("retry_hold", terminal_out_a, 1'b1);
    settle(14);
    check("retry_end", terminal_out_a, 1'b0);
    dig(`SOS_FC_TIMER, 1'b0, 1'b0);
    @(posedge clock);
    input_terminal <= 4'h4;
    settle(5);
    check("timer_wait_on", terminal_out_a, 1'b0);
    settle(25);
    check("timer_on", terminal_out_c, 1'b1);
    @(posedge clock);
    input_terminal <= 4'h0;
    settle(3);
    check("timer_wait_off", terminal_out_a, 1'b1);
    settle(27);
    check("timer_off", terminal_out_c, 1'b0);
    @(posedge clock);
    input_terminal <= 4'h4;
    repeat (4) @(posedge clock);
    input_terminal <= 4'h0;
    settle(30);
    check("timer_short", terminal_out_a, 1'b0);
    for (int k = 0; k < 15; k++)
      if (k != 4 && k != 11)
        mon(4'(k), 8'h64, 12'(16 * k + 1));
    mon(4'hf, 8'h64, 12'h000);
    @(posedge clock);
    volt_class_460 <= 1'b0;
    dc_bus_volts <= 10'h0c8;
    mon(`SOS_MON_DCV, 8'h64, 12'h7ff);
    @(posedge clock);
    volt_class_460 <= 1'b1;
    mon(`SOS_MON_DCV, 8'h64, 12'h3ff);
    @(posedge clock);
    dc_bus_volts <= 10'h3e8;
    mon(`SOS_MON_DCV, 8'h64, 12'hfff);
    mon(`SOS_MON_COMM, 8'h64, 12'hc00);
    mon(`SOS_MON_COMM, 8'h32, 12'h600);
    mon(`SOS_MON_COMM, 8'hc8, 12'hfff);
    mon(4'h1, 8'hc8, 12'h022);
    @(posedge clock);
    output_selector_b <= `SOS_FC_PULSE;
    rng(3'h4, 16'h1771, 1'b1);
    check("pulse_held_low", photocoupler_output, 1'b0);
    rng(3'h4, 16'h1770, 1'b0);
    rng(3'h0, 16'h017e, 1'b1);
    rng(3'h5, 16'h1000, 1'b1);
    for (int k = 4; k >= 0; k--)
      pulse_chk(3'(k), his[k], mults[k]);
    report_and_stop();
  end
endmodule
